// File: logic/tol_defs.vh
// Purpose: Constants for the thermal overload trip logic
// Assumes: 20 MHz clock, word-indexed register port
// Notes:   Percent values are in 0.1 % units
`ifndef TOL_DEFS_VH
`define TOL_DEFS_VH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define TOL_A_CTRL 4'h0
`define TOL_A_A1LVL 4'h1
`define TOL_A_A2LVL 4'h2
`define TOL_A_INHLVL 4'h3
`define TOL_A_TRPLVL 4'h4
`define TOL_A_TRPDLY 4'h5
`define TOL_A_SF 4'h6
`define TOL_A_KMAX 4'h7
`define TOL_A_KMIN 4'h8
`define TOL_A_TMIN 4'h9
`define TOL_A_TMAX 4'hA
`define TOL_A_INOM 4'hB
`define TOL_A_PICKUP 4'hC
`define TOL_A_STATUS 4'hD
`define TOL_A_MODE 4'hE

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TOL_C_EN1 0
`define TOL_C_EN2 1
`define TOL_C_ENINH 2
`define TOL_C_ALLOW 3
`define TOL_C_MODE_LO 4
`define TOL_C_MODE_HI 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TOL_R_A1LVL 11'h190
`define TOL_R_A2LVL 11'h190
`define TOL_R_INHLVL 11'h320
`define TOL_R_TRPLVL 11'h3E8
`define TOL_R_TRPDLY 20'h00000
`define TOL_R_SF 9'h064
`define TOL_R_K 9'h064
`define TOL_R_TMIN 10'h000
`define TOL_R_TMAX 10'h02D
`define TOL_R_INOM 12'h3E8
`define TOL_R_PICKUP 12'h3E8
`define TOL_K_ONE 9'h064
`define TOL_K_MAX 9'h1F4

// ----------------------------------------
// Load limits, current in 0.1 % of nominal
// ----------------------------------------
`define TOL_I_LIGHT 12'h00A
`define TOL_I_HIGH 12'h7D0

// ----------------------------------------
// Timing
// ----------------------------------------
`define TOL_CLK_NS 50
`define TOL_PCYC_NS 5000000
`define TOL_PCYC_CYC (`TOL_PCYC_NS / `TOL_CLK_NS)
`define TOL_BLK_LEAD_MS 5

`endif

// File: logic/tol_trip_logic.v
// Purpose: Alarm, inhibit and trip decisions of a machine
//          thermal overload stage, with blocking and status
// Assumes: Thermal capacity arrives from same-clock logic
// Notes:   Decisions are taken once per program cycle tick
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "tol_defs.vh"

// Operation
// - Alarm 1 output only when enabled
// - Alarm 1 at capacity reaching its level
// - Alarm 2 output only when enabled
// - Alarm 2 at capacity reaching its level
// - Inhibit when enabled and level reached
// - Trip at level after settable delay
// - Sample blocking at every program cycle start
// - Unblocked pick-up gives start, then timing
// - Blocked pick-up gives blocked, nothing more
// - Late blocking clears start, releases timer
// - Report condition; Normal drives no output but start
// - Report light load and high overload
// - Report overloading and normal load
// - Bad service factor: fault, use 1.0
// - Bad ambient settings: fault, use 1.0
// - Bad nominal current setting: fault, use 1.0
// - Flag inconsistent ambient coefficient settings
// - Show behaviour mode only when allowed
module tol_trip_logic #(
  parameter P_PCYC_CYC = `TOL_PCYC_CYC,
  parameter P_CAP_W = 11,
  parameter P_CUR_W = 12
) (
  input wire i_clk,
  input wire i_srst,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire [P_CAP_W-1:0] i_therm_cap,
  input wire [P_CUR_W-1:0] i_cur,
  input wire i_block,
  output wire o_alarm1,
  output wire o_alarm2,
  output wire o_inhibit,
  output wire o_trip,
  output wire o_start,
  output wire o_blocked,
  output wire o_pcyc_tick,
  output wire [2:0] o_condition,
  output wire [1:0] o_load_status,
  output wire [3:0] o_set_fault,
  output wire [8:0] o_sf_used,
  output wire [8:0] o_kmax_used,
  output wire [8:0] o_kmin_used,
  output wire [11:0] o_inom_used,
  output wire [2:0] o_node_mode,
  output wire o_node_mode_vis
);

  // ----------------------------------------
  // Local codes
  // ----------------------------------------
  localparam [2:0] COND_NORMAL = 3'h0;
  localparam [2:0] COND_A1 = 3'h1;
  localparam [2:0] COND_A2 = 3'h2;
  localparam [2:0] COND_INH = 3'h3;
  localparam [2:0] COND_TRIP = 3'h4;
  localparam [2:0] COND_BLK = 3'h5;
  localparam [1:0] LOAD_LIGHT = 2'h0;
  localparam [1:0] LOAD_NORMAL = 2'h1;
  localparam [1:0] LOAD_OVER = 2'h2;
  localparam [1:0] LOAD_HIGH = 2'h3;
  localparam [2:0] MODE_ON = 3'h0;
  localparam [2:0] MODE_BLK = 3'h1;
  localparam [2:0] MODE_TEST = 3'h2;
  localparam [2:0] MODE_TBLK = 3'h3;
  localparam [2:0] MODE_OFF = 3'h4;
  localparam [31:0] PCYC_END = P_PCYC_CYC - 1;
  localparam [16:0] PCYC_LAST = PCYC_END[16:0];

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  reg [6:0] ctrl_q;
  reg [10:0] a1_lvl_q;
  reg [10:0] a2_lvl_q;
  reg [10:0] inh_lvl_q;
  reg [10:0] trp_lvl_q;
  reg [19:0] trp_dly_q;
  reg [8:0] sf_q;
  reg [8:0] kmax_q;
  reg [8:0] kmin_q;
  reg [9:0] tmin_q;
  reg [9:0] tmax_q;
  reg [11:0] inom_q;
  reg [11:0] pickup_q;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [16:0] div_q;
  reg tick_q;
  reg blk_s1_q;
  reg blk_s2_q;
  reg a1_q;
  reg a2_q;
  reg inh_q;
  reg start_q;
  reg trip_q;
  reg blocked_q;
  reg [19:0] dly_cnt_q;
  reg [2:0] cond_q;
  reg [1:0] load_q;
  reg [2:0] cond_d;
  reg [1:0] load_d;
  reg [31:0] rdata_d;
  reg a1_d;
  reg a2_d;
  reg inh_d;
  reg start_d;
  reg trip_d;
  reg blocked_d;
  reg [19:0] dly_cnt_d;

  wire [2:0] mode;
  wire mode_off;
  wire mode_blk;
  wire blk_eff;
  wire pickup;
  wire sf_bad;
  wire amb_bad;
  wire inom_bad;
  wire kinc_bad;
  wire [10:0] cap;

  // ----------------------------------------
  // Program cycle divider
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      div_q <= 17'h00000;
      tick_q <= 1'b0;
    end else if (div_q == PCYC_LAST) begin
      div_q <= 17'h00000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 17'h00001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Blocking input synchroniser
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
    end else begin
      blk_s1_q <= i_block;
      blk_s2_q <= blk_s1_q;
    end
  end

  // ----------------------------------------
  // Behaviour mode
  // ----------------------------------------
  assign mode = ctrl_q[`TOL_C_MODE_HI:`TOL_C_MODE_LO];
  assign mode_off = (mode == MODE_OFF);
  assign mode_blk = (mode == MODE_BLK) || (mode == MODE_TBLK);
  assign blk_eff = blk_s2_q | mode_blk;
  assign cap = i_therm_cap[10:0];
  assign pickup = (cap >= trp_lvl_q);

  // ----------------------------------------
  // Decision logic, once per program cycle
  // ----------------------------------------
  always @* begin
    a1_d = ctrl_q[`TOL_C_EN1] & (cap >= a1_lvl_q);
    a2_d = ctrl_q[`TOL_C_EN2] & (cap >= a2_lvl_q);
    inh_d = ctrl_q[`TOL_C_ENINH] & (cap >= inh_lvl_q);
    start_d = 1'b0;
    trip_d = 1'b0;
    blocked_d = 1'b0;
    dly_cnt_d = 20'h00000;
    if (pickup && blk_eff) begin
      blocked_d = 1'b1;
    end else if (pickup) begin
      start_d = 1'b1;
      trip_d = (dly_cnt_q >= trp_dly_q);
      dly_cnt_d = trip_d ? dly_cnt_q : dly_cnt_q + 20'h00001;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst || mode_off) begin
      a1_q <= 1'b0;
      a2_q <= 1'b0;
      inh_q <= 1'b0;
      start_q <= 1'b0;
      trip_q <= 1'b0;
      blocked_q <= 1'b0;
      dly_cnt_q <= 20'h00000;
      cond_q <= COND_NORMAL;
    end else if (tick_q) begin
      a1_q <= a1_d;
      a2_q <= a2_d;
      inh_q <= inh_d;
      start_q <= start_d;
      trip_q <= trip_d;
      blocked_q <= blocked_d;
      dly_cnt_q <= dly_cnt_d;
      cond_q <= cond_d;
    end
  end

  // ----------------------------------------
  // Condition and load status
  // ----------------------------------------
  always @* begin
    if (trip_d) begin
      cond_d = COND_TRIP;
    end else if (blocked_d) begin
      cond_d = COND_BLK;
    end else if (inh_d) begin
      cond_d = COND_INH;
    end else if (a2_d) begin
      cond_d = COND_A2;
    end else if (a1_d) begin
      cond_d = COND_A1;
    end else begin
      cond_d = COND_NORMAL;
    end
    if (i_cur < `TOL_I_LIGHT) begin
      load_d = LOAD_LIGHT;
    end else if (i_cur > `TOL_I_HIGH) begin
      load_d = LOAD_HIGH;
    end else if (i_cur > pickup_q) begin
      load_d = LOAD_OVER;
    end else begin
      load_d = LOAD_NORMAL;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      load_q <= LOAD_LIGHT;
    end else if (tick_q) begin
      load_q <= load_d;
    end
  end

  // ----------------------------------------
  // Setting checks
  // ----------------------------------------
  assign sf_bad = (sf_q < `TOL_K_ONE) || (sf_q > `TOL_K_MAX);
  assign amb_bad = (kmax_q == 9'h000) || (kmax_q > `TOL_K_MAX) ||
                   (kmin_q == 9'h000) || (kmin_q > `TOL_K_MAX);
  assign inom_bad = (inom_q == 12'h000);
  assign kinc_bad = (tmin_q >= tmax_q);

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Normal condition keeps o_alarm1, o_alarm2, o_inhibit, o_trip and o_blocked low; o_start can be high while the trip delay runs
  assign o_alarm1 = a1_q;
  assign o_alarm2 = a2_q;
  assign o_inhibit = inh_q;
  assign o_trip = trip_q;
  assign o_start = start_q;
  assign o_blocked = blocked_q;
  assign o_pcyc_tick = tick_q;
  assign o_condition = cond_q;
  assign o_load_status = load_q;
  assign o_set_fault = {kinc_bad, inom_bad, amb_bad, sf_bad};
  assign o_sf_used = sf_bad ? `TOL_K_ONE : sf_q;
  assign o_kmax_used = amb_bad ? `TOL_K_ONE : kmax_q;
  assign o_kmin_used = amb_bad ? `TOL_K_ONE : kmin_q;
  assign o_inom_used = inom_bad ? {3'h0, `TOL_K_ONE} : inom_q;
  assign o_node_mode_vis = ctrl_q[`TOL_C_ALLOW];
  assign o_node_mode = ctrl_q[`TOL_C_ALLOW] ? mode : MODE_ON;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_q <= 7'h00;
      a1_lvl_q <= `TOL_R_A1LVL;
      a2_lvl_q <= `TOL_R_A2LVL;
      inh_lvl_q <= `TOL_R_INHLVL;
      trp_lvl_q <= `TOL_R_TRPLVL;
      trp_dly_q <= `TOL_R_TRPDLY;
      sf_q <= `TOL_R_SF;
      kmax_q <= `TOL_R_K;
      kmin_q <= `TOL_R_K;
      tmin_q <= `TOL_R_TMIN;
      tmax_q <= `TOL_R_TMAX;
      inom_q <= `TOL_R_INOM;
      pickup_q <= `TOL_R_PICKUP;
    end else if (i_wr) begin
      case (i_addr)
        `TOL_A_CTRL: ctrl_q <= i_wdata[6:0];
        `TOL_A_A1LVL: a1_lvl_q <= i_wdata[10:0];
        `TOL_A_A2LVL: a2_lvl_q <= i_wdata[10:0];
        `TOL_A_INHLVL: inh_lvl_q <= i_wdata[10:0];
        `TOL_A_TRPLVL: trp_lvl_q <= i_wdata[10:0];
        `TOL_A_TRPDLY: trp_dly_q <= i_wdata[19:0];
        `TOL_A_SF: sf_q <= i_wdata[8:0];
        `TOL_A_KMAX: kmax_q <= i_wdata[8:0];
        `TOL_A_KMIN: kmin_q <= i_wdata[8:0];
        `TOL_A_TMIN: tmin_q <= i_wdata[9:0];
        `TOL_A_TMAX: tmax_q <= i_wdata[9:0];
        `TOL_A_INOM: inom_q <= i_wdata[11:0];
        `TOL_A_PICKUP: pickup_q <= i_wdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    rdata_d = 32'h00000000;
    case (i_addr)
      `TOL_A_CTRL: begin
        rdata_d = {25'h0000000, ctrl_q};
      end
      `TOL_A_A1LVL: begin
        rdata_d = {21'h000000, a1_lvl_q};
      end
      `TOL_A_A2LVL: begin
        rdata_d = {21'h000000, a2_lvl_q};
      end
      `TOL_A_INHLVL: begin
        rdata_d = {21'h000000, inh_lvl_q};
      end
      `TOL_A_TRPLVL: begin
        rdata_d = {21'h000000, trp_lvl_q};
      end
      `TOL_A_TRPDLY: begin
        rdata_d = {12'h000, trp_dly_q};
      end
      `TOL_A_SF: begin
        rdata_d = {23'h000000, sf_q};
      end
      `TOL_A_KMAX: begin
        rdata_d = {23'h000000, kmax_q};
      end
      `TOL_A_KMIN: begin
        rdata_d = {23'h000000, kmin_q};
      end
      `TOL_A_TMIN: begin
        rdata_d = {22'h000000, tmin_q};
      end
      `TOL_A_TMAX: begin
        rdata_d = {22'h000000, tmax_q};
      end
      `TOL_A_INOM: begin
        rdata_d = {20'h00000, inom_q};
      end
      `TOL_A_PICKUP: begin
        rdata_d = {20'h00000, pickup_q};
      end
      `TOL_A_STATUS: begin
        rdata_d = {17'h00000, o_set_fault, load_q, cond_q,
                   blocked_q, start_q, trip_q, inh_q, a2_q, a1_q};
      end
      `TOL_A_MODE: begin
        rdata_d = {28'h0000000, o_node_mode_vis, o_node_mode};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // tol_trip_logic

// File: tb/tol_trip_logic_assertions.sv
// Purpose: Port checker for the thermal overload trip logic
// Assumes: Program cycle of at least 9 clocks
// Notes:   Bound into every instance of the top module
`timescale 1ns/100ps
module tol_chk #(
  parameter P_PCYC_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic o_alarm1,
  input wire logic o_alarm2,
  input wire logic o_inhibit,
  input wire logic o_trip,
  input wire logic o_start,
  input wire logic o_blocked,
  input wire logic o_pcyc_tick,
  input wire logic [2:0] o_condition,
  input wire logic [3:0] o_set_fault,
  input wire logic [8:0] o_sf_used,
  input wire logic [8:0] o_kmax_used,
  input wire logic [8:0] o_kmin_used,
  input wire logic [11:0] o_inom_used,
  input wire logic [2:0] o_node_mode,
  input wire logic o_node_mode_vis
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_tick;
    o_pcyc_tick |=> (!o_pcyc_tick) [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  property p_trip_tick;
    $rose(o_trip) |-> $past(o_pcyc_tick);
  endproperty
  a_trip_tick: assert property (p_trip_tick) else $error("trip off tick");
  property p_trip_cond;
    o_trip |-> o_condition == 3'h4;
  endproperty
  a_trip_cond: assert property (p_trip_cond) else $error("trip cond");
  property p_normal;
    o_condition == 3'h0 |-> !(o_alarm1 || o_alarm2 || o_inhibit ||
      o_trip || o_blocked);
  endproperty
  a_normal: assert property (p_normal) else $error("normal out");
  property p_start_blk;
    !(o_start && o_blocked);
  endproperty
  a_start_blk: assert property (p_start_blk) else $error("start+blk");
  property p_trip_start;
    o_trip |-> o_start;
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip alone");
  property p_sf;
    o_set_fault[0] |-> o_sf_used == 9'h064;
  endproperty
  a_sf: assert property (p_sf) else $error("sf override");
  property p_amb;
    o_set_fault[1] |-> o_kmax_used == 9'h064 && o_kmin_used == 9'h064;
  endproperty
  a_amb: assert property (p_amb) else $error("k override");
  property p_inom;
    o_set_fault[2] |-> o_inom_used == 12'h064;
  endproperty
  a_inom: assert property (p_inom) else $error("inom override");
  property p_mode;
    !o_node_mode_vis |-> o_node_mode == 3'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode shown");
endmodule // tol_chk

bind tol_trip_logic tol_chk #(.P_PCYC_CYC(P_PCYC_CYC)) tol_chk_i (
  .i_clk, .i_srst, .o_alarm1, .o_alarm2, .o_inhibit,
  .o_trip, .o_start, .o_blocked, .o_pcyc_tick,
  .o_condition, .o_set_fault, .o_sf_used, .o_kmax_used, .o_kmin_used,
  .o_inom_used, .o_node_mode, .o_node_mode_vis);

// File: tb/tol_blk_src.sv
// Purpose: Blocking matrix model feeding the blocking input
// Assumes: Request from the bench, same clock
// Notes:   Slow mode adds three clocks of lag
`timescale 1ns/100ps
module tol_blk_src (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_slow,
  output logic o_block
);
  logic [2:0] dly_q = 3'h0;
  initial o_block = 1'b0;
  always @(posedge i_clk) begin
    dly_q <= {dly_q[1:0], i_req};
    o_block <= i_slow ? dly_q[2] : i_req;
  end
endmodule // tol_blk_src

// File: tb/tol_trip_logic_tb.sv
// Purpose: Self-checking bench for the thermal overload trip logic
// Assumes: Program cycle shortened to 10 clocks
// Notes:   Reads are checked against a queue of expected words
`timescale 1ns/100ps
module tol_trip_logic_tb;
  localparam int PC = 10;
  localparam logic [31:0] DEF [13] = '{32'h0, 32'h190, 32'h190, 32'h320,
    32'h3E8, 32'h0, 32'h64, 32'h64, 32'h64, 32'h0, 32'h2D, 32'h3E8, 32'h3E8};
  localparam logic [11:0] CUR [6] = '{12'h009, 12'h00A, 12'h3E8, 12'h3E9,
    12'h7D0, 12'h7D1};
  localparam logic [3:0] FA [6] = '{4'h6, 4'h6, 4'h7, 4'h8, 4'hB, 4'h9};
  localparam logic [11:0] FB [6] = '{99, 501, 0, 501, 0, 45};
  localparam logic [11:0] FG [6] = '{100, 100, 100, 100, 1000, 0};
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [10:0] i_therm_cap = 11'h000;
  logic [11:0] i_cur = 12'h000;
  logic blk_req = 1'b0;
  logic blk_slow = 1'b0;
  logic rd_seen = 1'b0;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [31:0] lvl;
  wire i_block;
  wire [31:0] o_rdata;
  wire o_pcyc_tick;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  tol_trip_logic #(.P_PCYC_CYC(PC)) tol_trip_logic_i (.i_clk, .i_srst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_therm_cap, .i_cur,
    .i_block, .o_alarm1(), .o_alarm2(), .o_inhibit(), .o_trip(),
    .o_start(), .o_blocked(), .o_pcyc_tick, .o_condition(),
    .o_load_status(), .o_set_fault(), .o_sf_used(), .o_kmax_used(),
    .o_kmin_used(), .o_inom_used(), .o_node_mode(), .o_node_mode_vis());
  tol_blk_src tol_blk_src_i (.i_clk, .i_req(blk_req), .i_slow(blk_slow),
    .o_block(i_block));

  initial forever #25 i_clk = ~i_clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish;
    end
  end

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] x);
    num_checks++;
    if (got !== x) begin
      failures++;
      $display("mismatch at %0t: read %h expected %h", $time, got, x);
    end
  endtask

  always @(posedge i_clk) rd_seen <= i_rd;
  always @(negedge i_clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      cmp_rd(o_rdata & e[63:32], e[31:0]);
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic chk(input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    exp_q.push_back({m, x & m});
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clk);
      while (o_pcyc_tick !== 1'b1) @(posedge i_clk);
    end
    @(posedge i_clk);
  endtask

  initial begin
    void'($urandom(32'h37a43c09));
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    for (int k = 0; k < 13; k++) chk(k[3:0], 32'hFFFFFFFF, DEF[k]);
    wr(4'hF, 32'h5A5);
    wr(4'hD, 32'h3F);
    ticks(2);
    chk(4'hF, 32'hFFFFFFFF, 32'h0);
    chk(4'hD, 32'hFFFFFFFF, 32'h0);
    $display("done: defaults");
    wr(4'h1, 32'd100);
    wr(4'h2, 32'd200);
    wr(4'h3, 32'd300);
    wr(4'h4, 32'd400);
    wr(4'h0, 32'h7);
    for (int k = 0; k < 5; k++) begin
      i_therm_cap <= 11'(50 + 100 * k);
      ticks(2);
      lvl = (32'h1 << (k > 3 ? 5 : k)) - 32'h1;
      chk(4'hD, 32'h1FF, {23'h0, k[2:0], 6'h0} | lvl);
    end
    wr(4'h0, 32'h0);
    ticks(2);
    chk(4'hD, 32'h7, 32'h0);
    $display("done: thresholds");
    wr(4'h5, 32'h3);
    i_therm_cap <= 11'h000;
    ticks(2);
    i_therm_cap <= 11'd450;
    ticks(1);
    chk(4'hD, 32'h18, 32'h10);
    ticks(2);
    chk(4'hD, 32'h18, 32'h10);
    ticks(1);
    chk(4'hD, 32'h18, 32'h18);
    blk_req <= 1'b1;
    ticks(3);
    chk(4'hD, 32'h1F8, 32'h160);
    blk_slow <= 1'b1;
    blk_req <= 1'b0;
    ticks(3);
    chk(4'hD, 32'h30, 32'h10);
    i_therm_cap <= 11'h000;
    blk_req <= 1'b1;
    ticks(2);
    i_therm_cap <= 11'd450;
    ticks(2);
    chk(4'hD, 32'h38, 32'h20);
    blk_req <= 1'b0;
    $display("done: delay and blocking");
    lvl = $urandom_range(900, 10);
    wr(4'h1, lvl);
    wr(4'h0, 32'h1);
    i_therm_cap <= lvl[10:0] - 11'h001;
    ticks(2);
    chk(4'hD, 32'h1, 32'h0);
    i_therm_cap <= lvl[10:0];
    ticks(2);
    chk(4'hD, 32'h1, 32'h1);
    for (int k = 0; k < 6; k++) begin
      i_cur <= CUR[k];
      ticks(2);
      lvl = (12'hE94 >> (2 * k)) & 32'h3;
      chk(4'hD, 32'h600, lvl << 9);
    end
    $display("done: load");
    for (int k = 0; k < 6; k++) begin
      wr(FA[k], {20'h0, FB[k]});
      lvl = (12'hE50 >> (2 * k)) & 32'h3;
      chk(4'hD, 32'h7800, 32'h800 << lvl);
      wr(FA[k], {20'h0, FG[k]});
      chk(4'hD, 32'h7800, 32'h0);
    end
    wr(4'h0, 32'h7);
    i_therm_cap <= 11'd1000;
    ticks(2);
    wr(4'h0, 32'h4F);
    chk(4'hD, 32'h1FF, 32'h0);
    wr(4'h0, 32'h17);
    i_therm_cap <= 11'd450;
    ticks(2);
    chk(4'hD, 32'h1F8, 32'h160);
    i_therm_cap <= 11'h000;
    ticks(2);
    for (int k = 0; k < 5; k++) begin
      wr(4'h0, 32'h8 | (k << 4));
      chk(4'hE, 32'hF, 32'h8 | k);
    end
    wr(4'h0, 32'h40);
    chk(4'hE, 32'hF, 32'h0);
    $display("done: faults and mode");
    repeat (2) @(posedge i_clk);
    tally_and_finish;
  end
endmodule // tol_trip_logic_tb
